// ===== xds_pkg.sv
// Package: constants and carrier types of the data space decoder
package xds_pkg;

	// ==================== Register map ====================
	localparam logic [7:0] XDS_AUX_OFFSET = 8'h8e;
	localparam logic [7:0] XDS_AUX_RESET = 8'h08;
	localparam logic [7:0] XDS_AUX_WMASK = 8'hbf;
	localparam int XDS_BIT_PULLUP_DIS = 7;
	localparam int XDS_BIT_STRETCH = 5;
	localparam int XDS_BIT_SIZE_LO = 2;
	localparam int XDS_BIT_EXT_SEL = 1;
	localparam int XDS_BIT_ALE_SUPP = 0;

	// ==================== Internal data space ====================
	localparam logic [7:0] XDS_LOWER_TOP = 8'h7f;

	// ==================== Expanded RAM sizes ====================
	localparam int XDS_EXPANDED_RAM_DEPTH = 1792;
	localparam logic [11:0] XDS_SIZE_256 = 12'h100;
	localparam logic [11:0] XDS_SIZE_512 = 12'h200;
	localparam logic [11:0] XDS_SIZE_768 = 12'h300;
	localparam logic [11:0] XDS_SIZE_1024 = 12'h400;
	localparam logic [11:0] XDS_SIZE_1792 = 12'h700;
	localparam logic [11:0] XDS_SIZE_NONE = 12'h000;

	// ==================== Timing counts in clock periods ====================
	localparam logic [4:0] XDS_STROBE_SHORT = 5'h06;
	localparam logic [4:0] XDS_STROBE_LONG = 5'h1e;
	localparam logic [2:0] XDS_ALE_DIV_STD = 3'h6;
	localparam logic [2:0] XDS_ALE_DIV_X2 = 3'h3;

	// ==================== Types ====================
	typedef enum logic [1:0] {
		XDS_IDLE = 2'b00,
		XDS_ADDR = 2'b01,
		XDS_STRB = 2'b11,
		XDS_HOLD = 2'b10
	} xds_state_t;

	// Core internal data access
	typedef struct packed {
		logic req;
		logic direct;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} xds_iram_req_t;

	// Core external-data move
	typedef struct packed {
		logic req;
		logic use_data_pointer16;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} xds_movx_req_t;

	// Multiplexed external bus outputs
	typedef struct packed {
		logic [7:0] p0_out;
		logic p0_oe;
		logic [7:0] p2_out;
		logic p2_oe;
		logic ale;
		logic rd_n;
		logic wr_n;
	} xds_bus_t;

endpackage

// ===== xds_decoder.sv
// Module: internal data space decoder, expanded RAM and external move bus
`timescale 1ns/1ps
// Summary of operation
// - Lower 128 bytes, direct and indirect access
// - Upper 128 bytes reached indirectly only
// - Special registers above 7Fh, direct only
// - Addressing mode alone picks upper RAM or registers
// - Select clear sends moves to expanded RAM
// - Expanded RAM hits leave bus pins idle
// - Pointer moves beyond size run bus cycle
// - Above 0FFh only the 16-bit pointer reaches
// - Select set, indirect move drives 8-bit address
// - Select set, pointer move drives 16-bit address
// - External moves pulse read or write strobe
// - Strobes last 6 or 30 clock periods
// - Size field hides part of expanded RAM
// - Control bit 7 disables weak pull-ups
// - Address latch strobe free-running or moves only
// - Select bit loaded from security byte
// - Control register resets to 0000 10X0
module xds_decoder (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sec_ext_mem_select,
	input wire logic x2_mode,
	input wire xds_pkg::xds_iram_req_t iram_req,
	output logic [7:0] iram_rdata,
	output logic sfr_sel,
	input wire logic [7:0] sfr_rdata,
	input wire xds_pkg::xds_movx_req_t movx_req,
	output logic movx_ready,
	output logic movx_done,
	output logic [7:0] movx_rdata,
	output xds_pkg::xds_bus_t bus,
	input wire logic [7:0] p0_in,
	output logic weak_pullup_en,
	output logic [7:0] aux_memory_control
);
	import xds_pkg::*;

	typedef struct packed {
		xds_state_t st;
		logic [4:0] cnt;
		logic [2:0] div;
		logic [7:0] aux;
		logic boot_done;
		logic done;
		logic [7:0] rdata;
		logic [7:0] ird;
		logic mv_wr;
		logic [7:0] mv_wdata;
		xds_bus_t bus;
	} xds_regs_t;

	localparam xds_bus_t BUS_IDLE = '{p0_out: 8'h00, p0_oe: 1'b0, p2_out: 8'h00,
		p2_oe: 1'b0, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};

	xds_regs_t r;
	xds_regs_t next_r;
	logic [7:0] iram [256];
	logic [7:0] expanded_ram [XDS_EXPANDED_RAM_DEPTH];
	logic [11:0] expanded_ram_limit;
	logic [11:0] mv_addr12;
	logic expanded_ram_hit;
	logic mv_take;
	logic aux_hit;
	logic iram_hit;
	logic [4:0] strobe_len;
	logic [2:0] ale_div;

	// ==================== Decode ====================
	// Size field to accessible byte count; reserved codes hide all
	always_comb begin
		unique case (r.aux[XDS_BIT_SIZE_LO +: 3])
			3'b000: expanded_ram_limit = XDS_SIZE_256;
			3'b001: expanded_ram_limit = XDS_SIZE_512;
			3'b010: expanded_ram_limit = XDS_SIZE_768;
			3'b011: expanded_ram_limit = XDS_SIZE_1024;
			3'b100: expanded_ram_limit = XDS_SIZE_1792;
			default: expanded_ram_limit = XDS_SIZE_NONE;
		endcase
	end

	// Indirect moves carry only the low byte; high pointer bits matter only with the pointer
	assign mv_addr12 = movx_req.use_data_pointer16 ? ((movx_req.addr[15:12] == 4'h0) ?
		movx_req.addr[11:0] : 12'hfff) : {4'h0, movx_req.addr[7:0]};
	assign expanded_ram_hit = !r.aux[XDS_BIT_EXT_SEL] && (mv_addr12 < expanded_ram_limit);
	assign movx_ready = (r.st == XDS_IDLE);
	assign mv_take = movx_req.req && movx_ready;

	// Internal data: above 7Fh direct goes to registers, indirect to upper RAM
	assign iram_hit = iram_req.req && (!iram_req.direct ||
		iram_req.addr <= XDS_LOWER_TOP);
	assign sfr_sel = iram_req.req && iram_req.direct &&
		(iram_req.addr > XDS_LOWER_TOP) && (iram_req.addr != XDS_AUX_OFFSET);
	assign aux_hit = iram_req.req && iram_req.direct && (iram_req.addr == XDS_AUX_OFFSET);

	assign strobe_len = r.aux[XDS_BIT_STRETCH] ? XDS_STROBE_LONG : XDS_STROBE_SHORT;
	assign ale_div = x2_mode ? XDS_ALE_DIV_X2 : XDS_ALE_DIV_STD;

	// ==================== Next state ====================
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		// Security byte sets the select bit once after reset release
		if (!r.boot_done) begin
			next_r.boot_done = 1'b1;
			next_r.aux[XDS_BIT_EXT_SEL] = sec_ext_mem_select;
		end else if (aux_hit && iram_req.wr) begin
			next_r.aux = iram_req.wdata & XDS_AUX_WMASK;
		end
		// Internal read data, registered one cycle after the request
		if (iram_req.req && !iram_req.wr) begin
			if (aux_hit) begin
				next_r.ird = r.aux;
			end else if (iram_hit) begin
				next_r.ird = iram[iram_req.addr];
			end else begin
				next_r.ird = sfr_rdata;
			end
		end
		// Free-running latch strobe divider; it counts in every state so the rate stays even
		next_r.div = (r.div >= ale_div - 3'h1) ? 3'h0 : r.div + 3'h1;
		unique case (r.st)
			XDS_IDLE: begin
				// The latch strobe may pulse only while idle: a pulse in a strobe phase
				// would make an external address latch take data for address
				next_r.bus = BUS_IDLE;
				next_r.bus.ale = !r.aux[XDS_BIT_ALE_SUPP] && (r.div == 3'h0);
				if (mv_take) begin
					next_r.mv_wr = movx_req.wr;
					next_r.mv_wdata = movx_req.wdata;
					if (expanded_ram_hit) begin
						// On-chip access: bus pins stay untouched
						next_r.done = 1'b1;
						if (!movx_req.wr) begin
							next_r.rdata = expanded_ram[mv_addr12[10:0]];
						end
					end else begin
						next_r.st = XDS_ADDR;
						next_r.bus.ale = 1'b1;
						next_r.bus.p0_out = movx_req.addr[7:0];
						next_r.bus.p0_oe = 1'b1;
						next_r.bus.p2_out = movx_req.addr[15:8];
						next_r.bus.p2_oe = movx_req.use_data_pointer16;
					end
				end
			end
			XDS_ADDR: begin
				// Strobe phase: port 0 carries data on writes, floats on reads
				next_r.st = XDS_STRB;
				next_r.cnt = strobe_len - 5'h1;
				next_r.bus.ale = 1'b0;
				next_r.bus.p0_out = r.mv_wdata;
				next_r.bus.p0_oe = r.mv_wr;
				next_r.bus.wr_n = !r.mv_wr;
				next_r.bus.rd_n = r.mv_wr;
			end
			XDS_STRB: begin
				// Read data is taken on the last edge with the strobe low
				if (r.cnt == 5'h00) begin
					// Strobe rises; port 0 keeps write data one more cycle as hold time
					next_r.st = XDS_HOLD;
					next_r.bus.rd_n = 1'b1;
					next_r.bus.wr_n = 1'b1;
					if (!r.mv_wr) begin
						next_r.rdata = p0_in;
					end
				end else begin
					next_r.cnt = r.cnt - 5'h1;
				end
			end
			XDS_HOLD: begin
				next_r.st = XDS_IDLE;
				next_r.done = 1'b1;
				next_r.bus = BUS_IDLE;
			end
		endcase
	end

	// ==================== State register ====================
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r.st <= XDS_IDLE;
			r.cnt <= 5'h00;
			r.div <= 3'h0;
			r.aux <= XDS_AUX_RESET;
			r.boot_done <= 1'b0;
			r.done <= 1'b0;
			r.rdata <= 8'h00;
			r.ird <= 8'h00;
			r.mv_wr <= 1'b0;
			r.mv_wdata <= 8'h00;
			r.bus <= BUS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// ==================== Memories ====================
	// Internal RAM writes (lower and upper) and expanded RAM writes
	// Arrays have no reset: their contents are undefined until software writes them
	always_ff @(posedge clk) begin
		if (iram_req.req && iram_req.wr && iram_hit) begin
			iram[iram_req.addr] <= iram_req.wdata;
		end
		if (mv_take && movx_req.wr && expanded_ram_hit) begin
			expanded_ram[mv_addr12[10:0]] <= movx_req.wdata;
		end
	end

	// ==================== Outputs ====================
	assign iram_rdata = r.ird;
	assign movx_done = r.done;
	assign movx_rdata = r.rdata;
	assign bus = r.bus;
	assign aux_memory_control = r.aux;
	assign weak_pullup_en = !r.aux[XDS_BIT_PULLUP_DIS];

endmodule // xds_decoder

// ===== xds_checker.sv
// Port assertions of the data space decoder
`timescale 1ns/1ps
module xds_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire xds_pkg::xds_movx_req_t movx_req,
	input wire logic movx_ready,
	input wire logic movx_done,
	input wire xds_pkg::xds_bus_t bus,
	input wire logic weak_pullup_en,
	input wire logic [7:0] aux_memory_control
);
	import xds_pkg::*;
	logic [7:0] c;
	logic t;
	// Control value and a move taken at this edge
	assign c = aux_memory_control;
	assign t = movx_req.req && movx_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========
	// Checks
	property p_pu; weak_pullup_en == !c[7]; endproperty
	a_pu: assert property (p_pu) else $error("pullup");
	property p_rst; !$past(nrst) |-> c == 8'h08; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_hit; t && !c[1] && c[4:2] < 3'h5 && !movx_req.use_data_pointer16
		|=> movx_done && bus.rd_n && bus.wr_n && !bus.p0_oe; endproperty
	a_hit: assert property (p_hit) else $error("hit");
	property p_ind; t && c[1] && !movx_req.use_data_pointer16 |=> bus.ale && bus.p0_oe
		&& !bus.p2_oe && bus.p0_out == $past(movx_req.addr[7:0]); endproperty
	a_ind: assert property (p_ind) else $error("short addr");
	property p_dp; t && movx_req.use_data_pointer16 && (c[1] || movx_req.addr > 16'h06ff)
		|=> bus.ale && bus.p2_oe && bus.p2_out == $past(movx_req.addr[15:8]); endproperty
	a_dp: assert property (p_dp) else $error("long addr");
	property p_stb; t && c[1] && !movx_req.wr |-> ##2 !bus.rd_n && bus.wr_n; endproperty
	a_stb: assert property (p_stb) else $error("strobe");
	property p_sh; $fell(bus.rd_n) && !c[5] |-> !bus.rd_n [*6] ##1 bus.rd_n; endproperty
	a_sh: assert property (p_sh) else $error("short pulse");
	property p_lg; $fell(bus.wr_n) && c[5] |-> ##29 !bus.wr_n ##1 bus.wr_n; endproperty
	a_lg: assert property (p_lg) else $error("long pulse");
endmodule // xds_checker
bind xds_decoder xds_checker chk_u (.*);

// ===== xds_ext_mem.sv
// External memory on the multiplexed bus
`timescale 1ns/1ps
module xds_ext_mem (
	input wire logic clk,
	input wire xds_pkg::xds_bus_t bus,
	output logic [7:0] p0_in
);
	import xds_pkg::*;
	logic [7:0] mem [256];
	logic [7:0] la;
	logic [7:0] last = 8'h00;
	// Latch address, store writes, remember the byte read
	always @(posedge clk) begin
		if (bus.ale)
			la <= bus.p0_out ^ (bus.p2_oe ? bus.p2_out : 8'h00);
		if (!bus.wr_n)
			mem[la] <= bus.p0_out;
		if (!bus.rd_n)
			last <= mem[la];
	end
	// Released bus shows the inverted last byte
	assign p0_in = bus.rd_n ? ~last : mem[la];
endmodule // xds_ext_mem

// ===== tb_top.sv
// Self-checking bench of the data space decoder
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import xds_pkg::*;
	logic clk = 0;
	logic nrst = 0;
	logic rd_d = 0;
	logic ex, rdy, dn, ss, wpu;
	logic sec_sel = 0;
	logic x2 = 0;
	logic [3:0] na;
	logic [7:0] sfr_d = 0;
	logic [7:0] ird, mrd, p0i, v, w;
	logic [8:0] e;
	logic [15:0] a;
	xds_iram_req_t ireq = '0;
	xds_movx_req_t mreq = '0;
	xds_bus_t bus;
	logic [8:0] qm[$];
	logic [7:0] qi[$];
	logic [7:0] al[5] = '{8'h00, 8'h7f, 8'h80, 8'h8e, 8'hff};
	int sz[5] = '{256, 512, 768, 1024, 1792};
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	xds_decoder dut_u (.clk(clk), .nrst(nrst), .sec_ext_mem_select(sec_sel), .x2_mode(x2),
		.iram_req(ireq), .iram_rdata(ird), .sfr_sel(ss), .sfr_rdata(sfr_d),
		.movx_req(mreq), .movx_ready(rdy), .movx_done(dn), .movx_rdata(mrd), .bus(bus),
		.p0_in(p0i), .weak_pullup_en(wpu), .aux_memory_control());
	xds_ext_mem mem_u (.clk(clk), .bus(bus), .p0_in(p0i));
	// ==========
	// Tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic ir(input logic d, x, input logic [7:0] ad, dv);
		@(posedge clk);
		ireq <= '{1'b1, d, x, ad, dv};
		@(negedge clk);
		`CHK(ss, d && ad > 8'h7f && ad != XDS_AUX_OFFSET)
		@(posedge clk);
		ireq.req <= 1'b0;
	endtask
	// Count latch strobe pulses over 12 quiet clocks
	task automatic ale_cnt(input logic [3:0] ne);
		na = 4'h0;
		repeat (12) begin
			@(negedge clk);
			na = na + {3'h0, bus.ale};
		end
		`CHK(na, ne)
	endtask
	task automatic mv(input logic d, x, input logic [15:0] ad, input logic [7:0] dv, input logic xe);
		@(posedge clk);
		mreq <= '{1'b1, d, x, ad, dv};
		qm.push_back({!x, dv});
		ex = 0;
		@(negedge clk);
		while (!rdy) @(negedge clk);
		@(posedge clk);
		mreq.req <= 1'b0;
		@(negedge clk);
		`CHK(rdy, !xe)
		repeat (40) begin
			ex |= !bus.rd_n | !bus.wr_n;
			if (dn) break;
			@(negedge clk);
		end
		`CHK({ex, dn}, {xe, 1'b1})
	endtask
	// Take the oldest note whenever a result appears
	always @(posedge clk) begin
		if (rd_d) begin
			w = qi.pop_front();
			`CHK(ird, w)
		end
		rd_d <= ireq.req && !ireq.wr;
		if (dn) begin
			e = qm.pop_front();
			if (e[8]) `CHK(mrd, e[7:0])
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ==========
	// Main sequence
	initial begin
		void'($urandom(3255));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(wpu, 1'b1)
		ale_cnt(4'h2);
		ir(1, 0, 8'h8e, 0);
		qi.push_back(8'h08);
		v = 8'($urandom);
		ir(1, 1, 8'h8e, (v | 8'h80) & 8'hbf);
		ir(1, 0, 8'h8e, 0);
		qi.push_back((v | 8'h80) & 8'hbf);
		`CHK(wpu, 1'b0)
		// Indirect write, then direct or indirect read, then register read
		foreach (al[i]) begin
			v = 8'($urandom);
			sfr_d <= v ^ 8'h5a;
			ir(0, 1, al[i], v);
			ir(al[i] < 8'h80, 0, al[i], 0);
			qi.push_back(v);
			if (al[i] > 8'h7f && al[i] != 8'h8e) begin
				ir(1, 0, al[i], 0);
				qi.push_back(v ^ 8'h5a);
			end
		end
		// Size codes 000 to 100: last on-chip byte and first byte beyond; reserved code 101: first two bytes external
		for (int c = 0; c < 6; c++) begin
			ir(1, 1, 8'h8e, {3'b000, c[2:0], 2'b01});
			for (int k = 0; k < 2; k++) begin
				a = (c < 5) ? 16'(sz[c] - 1 + k) : 16'(k);
				v = 8'($urandom);
				mv(1, 1, a, v, c > 4 || k > 0);
				mv(1, 0, a, v, c > 4 || k > 0);
			end
		end
		// Short form drops the high byte
		ir(1, 1, 8'h8e, 8'h11);
		ale_cnt(4'h0);
		mv(0, 1, 16'h0305, v, 0);
		mv(1, 0, 16'h0005, v, 0);
		// Stack byte in upper RAM stays apart from expanded RAM at the same address
		ir(0, 1, 8'h8f, v);
		mv(0, 1, 16'h008f, ~v, 0);
		ir(0, 0, 8'h8f, 0);
		qi.push_back(v);
		// External select, both forms, plain and stretched strobes
		for (int s = 0; s < 2; s++) begin
			ir(1, 1, 8'h8e, {2'b00, s[0], 3'b000, 2'b11});
			a = 16'($urandom);
			v = 8'($urandom);
			mv(s[0], 1, a, v, 1);
			mv(s[0], 0, a, v, 1);
		end
		// Second reset in mid-run: select loaded from the security byte, fast latch strobe
		repeat (2) @(posedge clk);
		sec_sel <= 1'b1;
		x2 <= 1'b1;
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(wpu, 1'b1)
		ale_cnt(4'h4);
		ir(1, 0, 8'h8e, 0);
		qi.push_back(8'h0a);
		repeat (2) @(posedge clk);
		`CHK(qm.size() + qi.size(), 0)
		report_and_stop();
	end
endmodule // tb_top
